// file: common/gia_defs.vh
// constants for the grabber interrupt and acquisition status block
// assumes a 32-bit apb slave on a 50 mhz board clock
`ifndef GIA_DEFS_VH
`define GIA_DEFS_VH

// register byte offsets
`define GIA_OFF_STATUS   8'h00
`define GIA_OFF_ENABLE   8'h04
`define GIA_OFF_ENSET    8'h08
`define GIA_OFF_ENCLR    8'h0C
`define GIA_OFF_ACQCMD   8'h10
`define GIA_OFF_ACQSTAT  8'h14
`define GIA_OFF_SELECT   8'h18
`define GIA_OFF_SRCLVL   8'h1C

// interrupt source bit positions
`define GIA_IRQ_HW       0
`define GIA_IRQ_FIFO     1
`define GIA_IRQ_DMA      2
`define GIA_IRQ_EOF      3
`define GIA_IRQ_VBL      4
`define GIA_IRQ_COL      5
`define GIA_IRQ_TRIG     6
`define GIA_IRQ_SER      7
`define GIA_NIRQ         8

// acquisition state codes reported to software
`define GIA_ST_IDLE      2'h0
`define GIA_ST_SINGLE    2'h1
`define GIA_ST_CONT      2'h2

// acquisition command codes
`define GIA_CMD_SNAP     2'h0
`define GIA_CMD_GRAB     2'h1
`define GIA_CMD_FREEZE   2'h2
`define GIA_CMD_STOP     2'h3

// line column table
`define GIA_COL_AW       13
`define GIA_COL_WIN_BIT  7
`define GIA_COL_PTR_BIT  2

// engine select bit of the acquisition command word
`define GIA_ACQ_ENG_BIT  8
`define GIA_ZERO8        8'h00
`define GIA_ZERO32       32'h0000_0000
`endif

// file: rtl/gia_col_table.v
// one-bit-per-column marker memory for the line column interrupt
// assumes one write port from the bus and one read port from pixel count
`timescale 1ns/1ps
`include "gia_defs.vh"

module gia_col_table (
    input  wire                      clk_i,
    input  wire                      we_i,
    input  wire [`GIA_COL_AW-1:0]    waddr_i,
    input  wire                      wdata_i,
    input  wire [`GIA_COL_AW-1:0]    raddr_i,
    output reg                       rdata_o
);
    reg mem [0:(1<<`GIA_COL_AW)-1];

    // registered read keeps the memory inferable as block ram
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule

// file: rtl/gia_top.v
// interrupt enable/pending logic and acquisition state of a frame grabber
// assumes an apb master on clk_i; all event inputs come from pins or
// other domains and are synchronised here before use
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "gia_defs.vh"

module gia_top #(
    parameter TWO_ENGINES = 1
) (
    input  wire                      clk_i,
    input  wire                      resetn_i,
    // apb slave
    input  wire                      psel_i,
    input  wire                      penable_i,
    input  wire                      pwrite_i,
    input  wire [7:0]                paddr_i,
    input  wire [31:0]               pwdata_i,
    output reg  [31:0]               prdata_o,
    output reg                       pready_o,
    output reg                       pslverr_o,
    // event sources, asynchronous to clk_i
    input  wire                      hw_exception_i,
    input  wire                      fifo_overflow_i,
    input  wire                      dma_complete_i,
    input  wire                      frame_transfer_end_i,
    input  wire                      vblank_i,
    input  wire                      trigger_i,
    input  wire                      serial_request_i,
    input  wire                      frame_end_first_i,
    input  wire                      frame_end_second_i,
    input  wire [`GIA_COL_AW-1:0]    pixel_count_i,
    // pci interrupt request, active high level
    output reg                       irq_o
);
    // ************************************************************
    // synchronisers and edge detection
    // ************************************************************
    localparam NS = 9;
    wire [NS-1:0] raw_in = {frame_end_second_i, frame_end_first_i, serial_request_i,
                            trigger_i, vblank_i, frame_transfer_end_i,
                            dma_complete_i, fifo_overflow_i, hw_exception_i};
    reg  [NS-1:0] sync_a;
    reg  [NS-1:0] sync_b;
    reg  [NS-1:0] sync_c;
    reg  [`GIA_COL_AW-1:0] pix_a;
    reg  [`GIA_COL_AW-1:0] pix_b;
    reg  [`GIA_COL_AW-1:0] pix_c;
    reg  [`GIA_COL_AW-1:0] pix_seen;

    // two stages before any logic; third stage only holds history for edges and for the pixel count agreement check
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            sync_a <= {NS{1'b0}};
            sync_b <= {NS{1'b0}};
            sync_c <= {NS{1'b0}};
            pix_a  <= {`GIA_COL_AW{1'b0}};
            pix_b  <= {`GIA_COL_AW{1'b0}};
            pix_c  <= {`GIA_COL_AW{1'b0}};
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
            sync_c <= sync_b;
            pix_a  <= pixel_count_i;
            pix_b  <= pix_a;
            pix_c  <= pix_b;
        end
    end

    wire [NS-1:0] rise = sync_b & ~sync_c;
    wire [NS-1:0] fall = ~sync_b & sync_c;
    // pixel count is a bus that may be caught mid-change; a value is only
    // trusted once two samples agree, and each agreed value is checked once
    wire          pix_new = (pix_b == pix_c) && (pix_b != pix_seen);

    // ************************************************************
    // apb decode
    // ************************************************************
    wire acc   = psel_i & penable_i;
    wire wr    = acc & pwrite_i;

    function is_off;
        input [7:0] a;
        input [7:0] off;
        begin
            is_off = (a == off);
        end
    endfunction

    function mapped;
        input [7:0] a;
        begin
            mapped = is_off(a, `GIA_OFF_STATUS) | is_off(a, `GIA_OFF_ENABLE) |
                     is_off(a, `GIA_OFF_ENSET)  | is_off(a, `GIA_OFF_ENCLR)  |
                     is_off(a, `GIA_OFF_ACQCMD) | is_off(a, `GIA_OFF_ACQSTAT)|
                     is_off(a, `GIA_OFF_SELECT) | is_off(a, `GIA_OFF_SRCLVL);
        end
    endfunction

    // ************************************************************
    // line column table
    // ************************************************************
    // the table sits in the upper half of the map: one offset loads the
    // pointer, the other writes one marker bit and steps the pointer, so a
    // whole line can be filled by a run of writes without reloading it
    wire       col_hit;
    reg        col_check;
    wire       col_win    = wr & paddr_i[`GIA_COL_WIN_BIT];
    wire       col_ptr_wr = col_win & paddr_i[`GIA_COL_PTR_BIT];
    wire       col_we     = col_win & ~paddr_i[`GIA_COL_PTR_BIT];
    reg  [`GIA_COL_AW-1:0] col_waddr;

    gia_col_table u_col (
        .clk_i   (clk_i),
        .we_i    (col_we),
        .waddr_i (col_waddr),
        .wdata_i (pwdata_i[0]),
        .raddr_i (pix_b),
        .rdata_o (col_hit)
    );

    // column pointer register: write to 0x84 sets it, 0x80 writes the bit
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            col_waddr <= {`GIA_COL_AW{1'b0}};
        end else if (col_ptr_wr) begin
            col_waddr <= pwdata_i[`GIA_COL_AW-1:0];
        end else if (col_we) begin
            col_waddr <= col_waddr + {{(`GIA_COL_AW-1){1'b0}}, 1'b1};
        end
    end

    // the table read lags the count by one cycle, so the check lags too
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            col_check <= 1'b0;
            pix_seen  <= {`GIA_COL_AW{1'b0}};
        end else begin
            col_check <= pix_new;
            if (pix_new) begin
                pix_seen <= pix_b;
            end
        end
    end

    // ************************************************************
    // pending and enable registers
    // ************************************************************
    reg  [`GIA_NIRQ-1:0] pending;
    reg  [`GIA_NIRQ-1:0] enable;
    reg  [`GIA_NIRQ-1:0] events;

    // event vector, one pulse per detected condition
    always @* begin
        events                = `GIA_ZERO8;
        events[`GIA_IRQ_HW]   = rise[0];
        events[`GIA_IRQ_FIFO] = rise[1];
        events[`GIA_IRQ_DMA]  = rise[2];
        events[`GIA_IRQ_EOF]  = rise[3];
        events[`GIA_IRQ_VBL]  = rise[4] | fall[4];
        events[`GIA_IRQ_COL]  = col_check & col_hit;
        events[`GIA_IRQ_TRIG] = rise[5] | fall[5];
        events[`GIA_IRQ_SER]  = rise[6];
    end

    wire [`GIA_NIRQ-1:0] w1c = (wr && is_off(paddr_i, `GIA_OFF_STATUS)) ?
                               pwdata_i[`GIA_NIRQ-1:0] : `GIA_ZERO8;
    wire [`GIA_NIRQ-1:0] next_pending = (pending & ~w1c) | events;

    // pending keeps setting regardless of enable; a set beats a same-cycle clear
    // so an event that meets the host's clear is never lost
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            pending <= `GIA_ZERO8;
        end else begin
            pending <= next_pending;
        end
    end

    // enables: whole-word write, or set/clear masks touching only given bits
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            enable <= `GIA_ZERO8;
        end else if (wr && is_off(paddr_i, `GIA_OFF_ENABLE)) begin
            enable <= pwdata_i[`GIA_NIRQ-1:0];
        end else if (wr && is_off(paddr_i, `GIA_OFF_ENSET)) begin
            enable <= enable | pwdata_i[`GIA_NIRQ-1:0];
        end else if (wr && is_off(paddr_i, `GIA_OFF_ENCLR)) begin
            enable <= enable & ~pwdata_i[`GIA_NIRQ-1:0];
        end
    end

    // level interrupt computed from the next pending so it tracks clears at once
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(next_pending & enable);
        end
    end

    // ************************************************************
    // acquisition engines
    // ************************************************************
    localparam S_IDLE   = 3'b001;
    localparam S_SINGLE = 3'b010;
    localparam S_CONT   = 3'b100;

    reg        sel;
    wire [2:0] sel_st;
    wire       cmd_wr = wr && is_off(paddr_i, `GIA_OFF_ACQCMD);
    wire [1:0] cmd    = pwdata_i[1:0];
    wire       cmd_eng = pwdata_i[`GIA_ACQ_ENG_BIT];
    wire [1:0] frame_end = {rise[8], rise[7]};

    function [1:0] st_code;
        input [2:0] s;
        begin
            case (s)
                S_SINGLE: st_code = `GIA_ST_SINGLE;
                S_CONT:   st_code = `GIA_ST_CONT;
                default:  st_code = `GIA_ST_IDLE;
            endcase
        end
    endfunction

    // engine select register; single-engine build pins it to the first
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            sel <= 1'b0;
        end else if (wr && is_off(paddr_i, `GIA_OFF_SELECT) && TWO_ENGINES != 0) begin
            sel <= pwdata_i[0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : eng
            reg  [2:0] st;
            reg        freeze_pend;
            wire       hit = cmd_wr && (cmd_eng == (g == 1)) &&
                             (g == 0 || TWO_ENGINES != 0);
            // each engine runs its own state machine on its own frame end
            always @(posedge clk_i) begin
                if (!resetn_i) begin
                    st          <= S_IDLE;
                    freeze_pend <= 1'b0;
                end else if (hit && cmd == `GIA_CMD_STOP) begin
                    st          <= S_IDLE;
                    freeze_pend <= 1'b0;
                end else begin
                    case (st)
                        S_IDLE: begin
                            if (hit && cmd == `GIA_CMD_SNAP) begin
                                st <= S_SINGLE;
                            end else if (hit && cmd == `GIA_CMD_GRAB) begin
                                st <= S_CONT;
                            end
                        end
                        // grab and freeze are ignored; the snap ends on its own frame
                        S_SINGLE: begin
                            if (frame_end[g]) begin
                                st <= S_IDLE;
                            end
                        end
                        S_CONT: begin
                            if (hit && cmd == `GIA_CMD_FREEZE) begin
                                freeze_pend <= 1'b1;
                            end
                            // stay continuous until frame ends after freeze
                            if (frame_end[g] && (freeze_pend ||
                                (hit && cmd == `GIA_CMD_FREEZE))) begin
                                st          <= S_IDLE;
                                freeze_pend <= 1'b0;
                            end
                        end
                        default: begin
                            st <= S_IDLE;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // exactly one of three codes, from the selected engine
    assign sel_st = sel ? eng[1].st : eng[0].st;
    wire [1:0] acq_code = st_code(sel_st);

    // ************************************************************
    // apb read and response
    // ************************************************************
    reg [31:0] next_rdata;
    always @* begin
        next_rdata = `GIA_ZERO32;
        case (paddr_i)
            `GIA_OFF_STATUS:  next_rdata[`GIA_NIRQ-1:0] = pending;
            `GIA_OFF_ENABLE:  next_rdata[`GIA_NIRQ-1:0] = enable;
            `GIA_OFF_ACQSTAT: next_rdata[1:0] = acq_code;
            `GIA_OFF_SELECT:  next_rdata[0] = sel;
            `GIA_OFF_SRCLVL:  next_rdata[NS-1:0] = sync_b;
            default:          next_rdata = `GIA_ZERO32;
        endcase
    end

    // no wait state: ready is raised at the setup edge so that it stands in
    // the access cycle; prdata is only reloaded at a setup edge and so holds
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            prdata_o  <= `GIA_ZERO32;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else if (psel_i && !penable_i) begin
            prdata_o  <= next_rdata;
            pready_o  <= 1'b1;
            pslverr_o <= ~(mapped(paddr_i) | paddr_i[`GIA_COL_WIN_BIT]);
        end else begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end
endmodule

// file: testbench/gia_host.sv
// model of the host driver: an apb master with enable and service helpers
// assumes gia_top answers each access with one pready pulse
`timescale 1ns/1ps
`include "gia_defs.vh"
module gia_host (
    input  wire logic        clk_i,
    input  wire logic [31:0] prdata_i,
    input  wire logic        pready_i,
    input  wire logic        pslverr_i,
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic [7:0]       paddr_o,
    output logic [31:0]      pwdata_o
);
    int to = 0;
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'hFF;
        pwdata_o = 32'h0;
    end
    // one transfer; released lines show the inverse so stale values cannot match
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_i !== 1'b1 && n < 20);
        // a slave that never answers ends the run through the bench's report
        if (pready_i !== 1'b1) begin
            to++;
            gia_top_bench.close_out();
        end
        q = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        paddr_o <= ~a;
        pwdata_o <= ~d;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        xfer(1'b1, a, d, q, e);
    endtask
    // each enable is set or cleared alone through its own strobe register
    task automatic en(input int b, input bit on);
        wr(on ? `GIA_OFF_ENSET : `GIA_OFF_ENCLR, 32'h1 << b);
    endtask
    // the driver clears only the source it serviced
    task automatic clear_bit(input int b);
        wr(`GIA_OFF_STATUS, 32'h1 << b);
    endtask
endmodule

// file: testbench/gia_irq_monitor.sv
// checker for the interrupt and acquisition status block
// assumes it is bound to gia_top and sees only its ports
`timescale 1ns/1ps
`include "gia_defs.vh"
module gia_irq_monitor #(
    parameter TWO_ENGINES = 1
) (
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        hw_exception_i,
    input wire logic        fifo_overflow_i,
    input wire logic        dma_complete_i,
    input wire logic        frame_transfer_end_i,
    input wire logic        vblank_i,
    input wire logic        trigger_i,
    input wire logic        serial_request_i,
    input wire logic        frame_end_first_i,
    input wire logic        frame_end_second_i,
    input wire logic [12:0] pixel_count_i,
    input wire logic        irq_o
);
    logic [7:0] cause;
    logic [3:0] wr_h;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // recent pin changes or writes; the synchronisers delay effects by several cycles
    always @(posedge clk_i) begin
        cause <= {cause[6:0], wr_h[0] | $changed({hw_exception_i, fifo_overflow_i,
            dma_complete_i, frame_transfer_end_i, vblank_i, trigger_i,
            serial_request_i, pixel_count_i})};
        wr_h <= {wr_h[2:0], psel_i & penable_i & pwrite_i};
    end
    AST_RST_QUIET: assert property ($rose(resetn_i) |-> !irq_o)
        else $error("irq high right after reset");
    AST_IRQ_CAUSE: assert property ($rose(irq_o) |-> |cause)
        else $error("irq rose with no cause");
    AST_IRQ_DROP: assert property ($fell(irq_o) |-> |wr_h)
        else $error("irq fell with no write");
    AST_READY_NEXT: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    AST_READY_PULSE: assert property (pready_o |=> !pready_o)
        else $error("ready held two cycles");
    AST_READY_ACC: assert property (pready_o |-> psel_i && penable_i)
        else $error("ready outside access");
    AST_ERR_ZERO: assert property (pslverr_o && !pwrite_i |-> prdata_o == `GIA_ZERO32)
        else $error("refused read not zero");
    AST_ERR_MAP: assert property (pready_o && paddr_i == `GIA_OFF_STATUS |-> !pslverr_o)
        else $error("mapped access refused");
    AST_STATE_CODE: assert property (pready_o && !pwrite_i &&
        paddr_i == `GIA_OFF_ACQSTAT |-> prdata_o < 32'h3)
        else $error("bad state code");
    cover property ($rose(irq_o));
    cover property ($fell(irq_o));
    cover property (pslverr_o);
endmodule
bind gia_top gia_irq_monitor #(.TWO_ENGINES(TWO_ENGINES)) mon (.*);

// file: testbench/gia_top_bench.sv
// self-checking bench for gia_top with a behavioural model of pending and state
// assumes gia_host as bus master and events driven at clock edges
`timescale 1ns/1ps
`include "gia_defs.vh"
module gia_top_bench;
    logic clk, resetn, psel, penable, pwrite, pready, pslverr, irq, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, p1;
    logic [9:0] lv;
    logic [12:0] pix, col;
    int failures = 0, tests_run = 0, pend = 0, ena = 0, m, i, eng;
    int st[2] = '{0, 0}, fz[2] = '{0, 0};
    gia_top #(.TWO_ENGINES(1)) DUT (.clk_i(clk), .resetn_i(resetn), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .hw_exception_i(lv[0]), .fifo_overflow_i(lv[1]), .dma_complete_i(lv[2]),
        .frame_transfer_end_i(lv[3]), .vblank_i(lv[4]), .trigger_i(lv[6]),
        .serial_request_i(lv[7]), .frame_end_first_i(lv[8]),
        .frame_end_second_i(lv[9]), .pixel_count_i(pix), .irq_o(irq));
    // single-engine build on the same pins; only its read data is watched
    gia_top #(.TWO_ENGINES(0)) DUT1 (.clk_i(clk), .resetn_i(resetn), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(p1), .pready_o(), .pslverr_o(),
        .hw_exception_i(lv[0]), .fifo_overflow_i(lv[1]), .dma_complete_i(lv[2]),
        .frame_transfer_end_i(lv[3]), .vblank_i(lv[4]), .trigger_i(lv[6]),
        .serial_request_i(lv[7]), .frame_end_first_i(lv[8]),
        .frame_end_second_i(lv[9]), .pixel_count_i(pix), .irq_o());
    gia_host host (.clk_i(clk), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr),
        .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
        .pwdata_o(pwdata));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic close_out;
        failures += host.to;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input int x, input string n);
        host.xfer(1'b0, a, 32'h0, q, e);
        chk(n, x, q);
        if (a == `GIA_OFF_ACQSTAT) chk("single engine state", st[0], p1);
    endtask
    // levels 4 and 6 toggle, column moves the count, the rest pulse
    task automatic fire(input int k);
        @(posedge clk);
        if (k == 5) pix <= col;
        else lv[k] <= ~lv[k];
        @(posedge clk);
        if (k != 4 && k != 5 && k != 6) lv[k] <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    // command plus model update, then read back the selected engine
    task automatic acq(input int c, input int g);
        host.wr(`GIA_OFF_ACQCMD, (g << 8) | c);
        if (c == 0) st[g] = 1;
        if (c == 1) st[g] = 2;
        if (c == 2) fz[g] = (st[g] == 2);
        if (c == 3) st[g] = 0;
        rdchk(`GIA_OFF_ACQSTAT, st[g], "state");
    endtask
    initial begin
        resetn = 1'b0;
        lv = 10'h0;
        pix = 13'h0;
        void'($urandom(43456));
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        rdchk(`GIA_OFF_STATUS, 0, "pending");
        rdchk(`GIA_OFF_ENABLE, 0, "enable");
        host.xfer(1'b0, 8'h40, 32'h0, q, e);
        chk("unmapped", 32'h1, {31'h0, e});
        $display("test reset done");
        col = 13'(1 + $urandom % 8191);
        host.wr(8'h84, col);
        host.wr(8'h80, 32'h1);
        for (i = 0; i < 8; i++) begin
            fire(i);
            pend |= 1 << i;
            rdchk(`GIA_OFF_STATUS, pend, "pending");
            chk("irq", 0, {31'h0, irq});
        end
        $display("test sources done");
        m = 1 + $urandom % 255;
        for (i = 0; i < 8; i++) if (m[i]) host.en(i, 1'b1);
        ena = m;
        rdchk(`GIA_OFF_ENABLE, ena, "enable");
        repeat (3) @(posedge clk);
        chk("irq", 1, {31'h0, irq});
        for (i = 0; i < 8; i++) begin
            host.clear_bit(i);
            pend &= ~(1 << i);
            repeat (3) @(posedge clk);
            chk("irq", (pend & ena) != 0, {31'h0, irq});
            rdchk(`GIA_OFF_STATUS, pend, "pending");
            host.en(i, 1'b0);
            ena &= ~(1 << i);
            rdchk(`GIA_OFF_ENABLE, ena, "enable");
        end
        $display("test enables done");
        fire(4);
        fire(6);
        rdchk(`GIA_OFF_STATUS, 32'h50, "pending");
        host.wr(`GIA_OFF_STATUS, 32'h50);
        $display("test second edges done");
        for (eng = 0; eng < 2; eng++) begin
            host.wr(`GIA_OFF_SELECT, eng);
            acq(1, eng);
            acq(2, eng);
            fire(8 + eng);
            if (fz[eng] != 0) st[eng] = 0;
            rdchk(`GIA_OFF_ACQSTAT, st[eng], "state");
            acq(0, eng);
            host.wr(`GIA_OFF_SELECT, 1 - eng);
            rdchk(`GIA_OFF_ACQSTAT, st[1 - eng], "state");
            host.wr(`GIA_OFF_SELECT, eng);
            acq(3, eng);
            acq(0, eng);
            fire(8 + eng);
            st[eng] = 0;
            rdchk(`GIA_OFF_ACQSTAT, st[eng], "state");
        end
        $display("test engines done");
        close_out();
    end
endmodule
